// ---- hdl/ascbd_top.sv ----
// Serial control byte decoder and result shifter of the converter front end.
// Notes on behaviour
// R1 - Host sends a control byte per conversion.
// R2 - Leading zeros ignored; first one starts byte.
// R3 - Bits 6..4 pick one of eight inputs.
// R4 - Bit 3: one unipolar, zero bipolar.
// R5 - Bit 2: one single-ended, zero differential.
// R6 - Low two bits set clock and power mode.
// R7 - Modes: 00 full, 01 fast, 10 int, 11 ext.
// R8 - All-ones byte converts input eight, external clock.
// R9 - Strobe high one period before result MSB.
// R10 - Twelve decisions on following falling edges.
// R11 - Continuous ones input needs fifteen clocks per conversion.
// R12 - Strobe and data change on falling edges only; here chip select high also clears both at once.
//
// The address-and-strobe port and the register offsets are this design's own decisions.
module ascbd_top
    import ascbd_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        reset_n,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    input  wire logic        sclk,
    input  wire logic        cs_n,
    input  wire logic        din,
    output logic             dout_o,
    output logic             dout_oe,
    output logic             conversion_strobe_out,
    output logic             conversion_strobe_oe
);

    // ****************************************************************
    // System clock reset
    // ****************************************************************
    logic rst_ff1_reg;
    logic rst_n_sync;

    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rst_ff1_reg <= 1'b0;
            rst_n_sync  <= 1'b0;
        end
        else
        begin
            rst_ff1_reg <= 1'b1;
            rst_n_sync  <= rst_ff1_reg;
        end
    end

    // ****************************************************************
    // Register bus
    // ****************************************************************
    logic [7:0][9:0] sample_reg;
    logic [7:0][9:0] snap_reg;
    logic            snap_req_reg;
    logic            ack_ff1_reg;
    logic            ack_ff2_reg;
    logic            ct_ff1_reg;
    logic            ct_ff2_reg;
    logic            ct_ff3_reg;
    ascbd_ctrl_t     last_ctrl_reg;
    logic [15:0]     conv_count_reg;
    logic [31:0]     reg_rdata_next;
    ascbd_ctrl_t     ctrl_hold_reg;
    logic            ctrl_tgl_reg;
    logic            ack_reg;

    wire        hit_sample  = (reg_addr[7:5] == SAMPLE_BASE[7:5]) && (reg_addr[1:0] == 2'h0);
    wire        hit_status  = (reg_addr == STATUS_ADDR);
    wire [2:0]  sample_idx  = reg_addr[4:2];
    wire        snap_busy   = (snap_req_reg != ack_ff2_reg);
    wire        snap_stale  = (sample_reg != snap_reg);
    wire        ctrl_event  = (ct_ff2_reg != ct_ff3_reg);
    // R7 - power mode decode
    wire        stat_pd     = (last_ctrl_reg.mode == MODE_FULL_PD) ||
                              (last_ctrl_reg.mode == MODE_FAST_PD);
    wire        stat_ext    = (last_ctrl_reg.mode == MODE_EXT_CLK);
    wire [31:0] status_word = {conv_count_reg, 6'h00, stat_ext, stat_pd, last_ctrl_reg};

    always_comb
    begin
        reg_rdata_next = 32'h0000_0000;
        if (hit_sample)
        begin
            reg_rdata_next[9:0] = sample_reg[sample_idx];
        end
        else if (hit_status)
        begin
            reg_rdata_next = status_word;
        end
    end

    always_ff @(posedge mclk or negedge rst_n_sync)
    begin
        if (!rst_n_sync)
        begin
            sample_reg <= '0;
            reg_rdata  <= 32'h0000_0000;
        end
        else
        begin
            if (reg_wr && hit_sample)
            begin
                sample_reg[sample_idx] <= reg_wdata[9:0];
            end
            reg_rdata <= reg_rd ? reg_rdata_next : 32'h0000_0000;
        end
    end

    // Sample table is handed to the link side whole; it waits for the ack so the
    // link side never latches a word while it is changing.
    always_ff @(posedge mclk or negedge rst_n_sync)
    begin
        if (!rst_n_sync)
        begin
            snap_reg     <= '0;
            snap_req_reg <= 1'b0;
            ack_ff1_reg  <= 1'b0;
            ack_ff2_reg  <= 1'b0;
        end
        else
        begin
            ack_ff1_reg <= ack_reg;
            ack_ff2_reg <= ack_ff1_reg;
            if (!snap_busy && snap_stale)
            begin
                snap_reg     <= sample_reg;
                snap_req_reg <= ~snap_req_reg;
            end
        end
    end

    // The captured byte stays still for at least eight link clocks, far longer
    // than the toggle takes to cross.
    always_ff @(posedge mclk or negedge rst_n_sync)
    begin
        if (!rst_n_sync)
        begin
            ct_ff1_reg     <= 1'b0;
            ct_ff2_reg     <= 1'b0;
            ct_ff3_reg     <= 1'b0;
            last_ctrl_reg  <= '0;
            conv_count_reg <= 16'h0000;
        end
        else
        begin
            ct_ff1_reg <= ctrl_tgl_reg;
            ct_ff2_reg <= ct_ff1_reg;
            ct_ff3_reg <= ct_ff2_reg;
            if (ctrl_event)
            begin
                last_ctrl_reg  <= ctrl_hold_reg;
                conv_count_reg <= conv_count_reg + 16'h0001;
            end
        end
    end

    // ****************************************************************
    // Link clock reset and table copy
    // ****************************************************************
    logic            srst_ff1_reg;
    logic            srst_n;
    logic            rq_ff1_reg;
    logic            rq_ff2_reg;
    logic [7:0][9:0] copy_reg;

    always_ff @(posedge sclk or negedge rst_n_sync)
    begin
        if (!rst_n_sync)
        begin
            srst_ff1_reg <= 1'b0;
            srst_n       <= 1'b0;
        end
        else
        begin
            srst_ff1_reg <= 1'b1;
            srst_n       <= srst_ff1_reg;
        end
    end

    always_ff @(posedge sclk or negedge srst_n)
    begin
        if (!srst_n)
        begin
            rq_ff1_reg <= 1'b0;
            rq_ff2_reg <= 1'b0;
            ack_reg    <= 1'b0;
            copy_reg   <= '0;
        end
        else
        begin
            rq_ff1_reg <= snap_req_reg;
            rq_ff2_reg <= rq_ff1_reg;
            if (rq_ff2_reg != ack_reg)
            begin
                copy_reg <= snap_reg;
                ack_reg  <= rq_ff2_reg;
            end
        end
    end

    // ****************************************************************
    // Control byte receiver
    // ****************************************************************
    ascbd_rx_t rx_state_reg;
    logic [2:0] bit_cnt_reg;
    logic [6:0] rx_shift_reg;
    logic       byte_done_reg;
    logic       int_mode_reg;

    // Chip select high ends the frame at once, even with the link clock stopped.
    wire        frame_clr = cs_n | ~srst_n;
    wire        last_bit  = (rx_state_reg == ASCBD_RX_SHIFT) && (bit_cnt_reg == LAST_CTRL_BIT);
    wire [7:0]  rx_byte   = {rx_shift_reg, din};

    always_ff @(posedge sclk or posedge frame_clr)
    begin
        if (frame_clr)
        begin
            rx_state_reg  <= ASCBD_RX_HUNT;
            bit_cnt_reg   <= 3'h0;
            rx_shift_reg  <= 7'h00;
            byte_done_reg <= 1'b0;
        end
        else
        begin
            byte_done_reg <= last_bit;
            unique case (rx_state_reg)
                ASCBD_RX_HUNT:
                begin
                    // R2 - start bit hunt
                    if (din)
                    begin
                        rx_state_reg <= ASCBD_RX_SHIFT;
                        rx_shift_reg <= 7'h01;
                        bit_cnt_reg  <= FIRST_CTRL_BIT;
                    end
                end
                ASCBD_RX_SHIFT:
                begin
                    rx_shift_reg <= rx_byte[6:0];
                    if (last_bit)
                    begin
                        rx_state_reg <= ASCBD_RX_BUSY;
                        bit_cnt_reg  <= 3'h0;
                    end
                    else
                    begin
                        bit_cnt_reg <= bit_cnt_reg + 3'h1;
                    end
                end
                ASCBD_RX_BUSY:
                begin
                    // R11 - input ignored during conversion
                    if (bit_cnt_reg == IGNORE_RISES - 3'h1)
                    begin
                        rx_state_reg <= ASCBD_RX_HUNT;
                        bit_cnt_reg  <= 3'h0;
                    end
                    else
                    begin
                        bit_cnt_reg <= bit_cnt_reg + 3'h1;
                    end
                end
            endcase
        end
    end

    // R1 - each byte triggers one conversion
    always_ff @(posedge sclk or negedge srst_n)
    begin
        if (!srst_n)
        begin
            ctrl_hold_reg <= '0;
            ctrl_tgl_reg  <= 1'b0;
            int_mode_reg  <= 1'b0;
        end
        else if (last_bit)
        begin
            ctrl_hold_reg <= rx_byte;
            ctrl_tgl_reg  <= ~ctrl_tgl_reg;
            // R6 - clock mode held
            int_mode_reg  <= (rx_byte[1:0] == MODE_INT_CLK);
        end
    end

    // ****************************************************************
    // Result selection
    // ****************************************************************
    // R3 - channel index from select bits
    wire [2:0] ch_plus  = {ctrl_hold_reg.sel[1:0], ctrl_hold_reg.sel[2]};
    wire [2:0] ch_minus = {ctrl_hold_reg.sel[1:0], ~ctrl_hold_reg.sel[2]};
    wire [9:0] v_plus   = copy_reg[ch_plus];
    wire [9:0] v_minus  = copy_reg[ch_minus];
    wire [10:0] v_diff  = {1'b0, v_plus} - {1'b0, v_minus};
    // R5 - single-ended or differential
    wire [9:0] se_code  = ctrl_hold_reg.polarity_select ? v_plus : (v_plus ^ BIPOLAR_FLIP);
    // R4 - unipolar clamps, bipolar halves signed
    wire [9:0] dif_code = ctrl_hold_reg.polarity_select ?
                          (v_diff[10] ? 10'h000 : v_diff[9:0]) : v_diff[10:1];
    wire [9:0] result   = ctrl_hold_reg.input_config_select ? se_code : dif_code;
    // R8 - all-ones byte lands here as external
    wire       conv_ext = (ctrl_hold_reg.mode == MODE_EXT_CLK);

    // ****************************************************************
    // Result shifter
    // ****************************************************************
    logic [11:0] out_shift_reg;
    logic [3:0]  out_cnt_reg;
    logic        wait_reg;
    logic        strobe_reg;
    logic        dout_reg;

    // R12 - outputs move on falling edges
    always_ff @(negedge sclk or posedge frame_clr)
    begin
        if (frame_clr)
        begin
            out_shift_reg <= 12'h000;
            out_cnt_reg   <= 4'h0;
            wait_reg      <= 1'b0;
            strobe_reg    <= 1'b0;
            dout_reg      <= 1'b0;
        end
        else if (byte_done_reg)
        begin
            // R9 - strobe pulse before MSB
            strobe_reg    <= conv_ext;
            wait_reg      <= ~conv_ext;
            out_shift_reg <= {result, 2'h0};
            out_cnt_reg   <= DECISIONS;
            dout_reg      <= 1'b0;
        end
        else if (wait_reg)
        begin
            // Internal conversion finishes at once; strobe rises a period later.
            strobe_reg <= 1'b1;
            wait_reg   <= 1'b0;
        end
        else if (out_cnt_reg != 4'h0)
        begin
            // R10 - one decision per falling edge
            strobe_reg    <= ~conv_ext;
            dout_reg      <= out_shift_reg[11];
            out_shift_reg <= {out_shift_reg[10:0], 1'b0};
            out_cnt_reg   <= out_cnt_reg - 4'h1;
        end
        else
        begin
            strobe_reg <= strobe_reg & ~conv_ext;
            dout_reg   <= 1'b0;
        end
    end

    assign dout_o                = dout_reg;
    assign dout_oe               = ~cs_n;
    assign conversion_strobe_out = strobe_reg;
    assign conversion_strobe_oe  = ~cs_n | int_mode_reg;

endmodule // ascbd_top

// ---- hdl/ascbd_pkg.sv ----
// Shared constants and types of the serial control byte decoder.
package ascbd_pkg;

    // ****************************************************************
    // Control byte and conversion framing
    // ****************************************************************
    typedef struct packed {
        logic       start;
        logic [2:0] sel;      // channel_select_bit_hi, _mid, _lo
        logic       polarity_select;
        logic       input_config_select;
        logic [1:0] mode;     // mode_field_hi, mode_field_lo
    } ascbd_ctrl_t;

    typedef enum {
        ASCBD_RX_HUNT,
        ASCBD_RX_SHIFT,
        ASCBD_RX_BUSY
    } ascbd_rx_t;

    localparam logic [1:0] MODE_FULL_PD = 2'h0;
    localparam logic [1:0] MODE_FAST_PD = 2'h1;
    localparam logic [1:0] MODE_INT_CLK = 2'h2;
    localparam logic [1:0] MODE_EXT_CLK = 2'h3;

    localparam logic [2:0] LAST_CTRL_BIT  = 3'h7;
    localparam logic [2:0] FIRST_CTRL_BIT = 3'h1;
    localparam logic [2:0] IGNORE_RISES   = 3'h7;
    localparam logic [3:0] DECISIONS      = 4'hC;
    localparam logic [9:0] BIPOLAR_FLIP   = 10'h200;

    // ****************************************************************
    // Register map
    // ****************************************************************
    localparam logic [7:0] SAMPLE_BASE  = 8'h00;
    localparam logic [7:0] STATUS_ADDR  = 8'h20;
    localparam int         STAT_PD_BIT  = 8;
    localparam int         STAT_EXT_BIT = 9;
    localparam int         STAT_CNT_LSB = 16;

endpackage

// ---- dv/ascbd_chk.sv ----
// Concurrent checks on the ports of the serial control byte decoder.
module ascbd_chk
    import ascbd_pkg::*;
(
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic din,
    input wire logic dout_o,
    input wire logic dout_oe,
    input wire logic conversion_strobe_out,
    input wire logic conversion_strobe_oe
);
    timeunit 1ns;
    timeprecision 1ns;
    // Shadow receiver: 0 hunts, 1 to 8 shift, 9 to 15 refuse a new start bit.
    logic [3:0]       cnt_reg;
    logic [7:0]       byte_reg;
    wire  logic [3:0] cnt_next = (cnt_reg == 4'h0 || cnt_reg == 4'hF) ? {3'h0, din}
                                                                       : cnt_reg + 4'h1;
    wire  logic       shift    = cnt_next != 4'h0 && cnt_next <= 4'h8;
    wire  logic       ext      = byte_reg[1:0] == MODE_EXT_CLK;
    always_ff @(posedge sclk or negedge reset_n or posedge cs_n)
        if (!reset_n || cs_n)
            cnt_reg <= 4'h0;
        else
            cnt_reg <= cnt_next;
    // The byte survives chip select so the idle strobe enable can be judged.
    always_ff @(posedge sclk or negedge reset_n)
        if (!reset_n)
            byte_reg <= 8'h00;
        else if (shift && !cs_n)
            byte_reg <= {byte_reg[6:0], din};
    property p_strb_ext;
        @(posedge sclk) disable iff (!reset_n || cs_n)
        cnt_reg == 4'h8 && ext |-> conversion_strobe_out ##1 !conversion_strobe_out [*6];
    endproperty
    a_strb_ext: assert property (p_strb_ext) else $error("external strobe pulse wrong");
    property p_strb_int;
        @(posedge sclk) disable iff (!reset_n || cs_n)
        cnt_reg == 4'h8 && !ext |-> !conversion_strobe_out ##1 conversion_strobe_out [*6];
    endproperty
    a_strb_int: assert property (p_strb_int) else $error("internal strobe timing wrong");
    property p_rose;
        @(posedge sclk) disable iff (!reset_n || cs_n)
        $rose(conversion_strobe_out) |-> (cnt_reg == 4'h8 && ext) || (cnt_reg == 4'h9 && !ext);
    endproperty
    a_rose: assert property (p_rose) else $error("strobe rose at wrong bit");
    property p_lead0;
        @(posedge sclk) disable iff (!reset_n || cs_n)
        cnt_reg == 4'h8 && ext |-> !dout_o;
    endproperty
    a_lead0: assert property (p_lead0) else $error("no leading zero beside strobe");
    property p_tail;
        @(posedge sclk) disable iff (!reset_n || cs_n)
        cnt_reg == 4'h8 && ext |-> ##11 !dout_o [*3];
    endproperty
    a_tail: assert property (p_tail) else $error("tail bits not zero");
    property p_edge;
        @(posedge mclk) disable iff (!reset_n || cs_n)
        !$past(cs_n) && ($changed(dout_o) || $changed(conversion_strobe_out))
            |-> !sclk && $past(sclk);
    endproperty
    a_edge: assert property (p_edge) else $error("output moved off a falling edge");
    property p_doe;
        @(posedge mclk) disable iff (!reset_n)
        dout_oe == !cs_n;
    endproperty
    a_doe: assert property (p_doe) else $error("data enable not following select");
    property p_soe;
        @(posedge mclk) disable iff (!reset_n)
        !cs_n |-> conversion_strobe_oe;
    endproperty
    a_soe: assert property (p_soe) else $error("strobe not driven in frame");
    property p_soe_ext;
        @(posedge mclk) disable iff (!reset_n)
        cs_n && ext |-> !conversion_strobe_oe;
    endproperty
    a_soe_ext: assert property (p_soe_ext) else $error("strobe driven while idle");
    // An internal clock conversion keeps its strobe driven after the frame ends.
    property p_soe_int;
        @(posedge mclk) disable iff (!reset_n)
        cs_n && byte_reg[1:0] == MODE_INT_CLK |-> conversion_strobe_oe;
    endproperty
    a_soe_int: assert property (p_soe_int) else $error("internal strobe released while idle");
    c_ext: cover property (@(posedge sclk) cnt_reg == 4'h8 && ext);
    c_int: cover property (@(posedge sclk) cnt_reg == 4'h8 && !ext);
    c_b2b: cover property (@(posedge sclk) cnt_reg == 4'hF && din);
endmodule // ascbd_chk
bind ascbd_top ascbd_chk u_chk (.mclk(mclk), .reset_n(reset_n), .sclk(sclk), .cs_n(cs_n),
    .din(din), .dout_o(dout_o), .dout_oe(dout_oe),
    .conversion_strobe_out(conversion_strobe_out),
    .conversion_strobe_oe(conversion_strobe_oe));

// ---- dv/ascbd_host.sv ----
// Host serial master model that frames control bytes and captures the reply.
module ascbd_host
(
    output logic      sclk,
    output logic      cs_n,
    output logic      din,
    input  wire logic dout
);
    timeunit 1ns;
    timeprecision 1ns;
    initial
    begin
        sclk = 1'b0;
        cs_n = 1'b1;
        din  = 1'b0;
    end
    // fresh byte per conversion
    // The clock idles low between frames; din is inverted on release so no stale level lingers.
    task automatic frame(input logic [39:0] pat, output logic [40:1] cap);
        #13 cs_n = 1'b0;
        for (int k = 1; k <= 40; k++)
        begin
            din = pat[40 - k];
            #40 sclk = 1'b1;
            cap[k] = dout;
            #40 sclk = 1'b0;
        end
        #40 cs_n = 1'b1;
        din = ~din;
    endtask
endmodule // ascbd_host

// ---- dv/tb_top.sv ----
// Self-checking bench of the serial control byte decoder.
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin $display("[FAIL] %s exp %h got %h", n, e, g); error_cnt++; end end
module tb_top
    import ascbd_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic        mclk      = 1'b0;
    logic        reset_n   = 1'b0;
    logic [7:0]  reg_addr  = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic        reg_wr    = 1'b0;
    logic        reg_rd    = 1'b0;
    logic [31:0] reg_rdata;
    logic        sclk, cs_n, din, dout_o, dout_oe, strb, strb_oe;
    int          error_cnt = 0;
    int          tests_run = 0;
    logic [9:0]  smp [8];
    logic [40:1] cap;
    logic [7:0]  tbl [6]   = '{8'hFF, 8'hB6, 8'hCB, 8'h93, 8'hAC, 8'h8D};
    wire  logic  dout_w    = dout_oe ? dout_o : 1'bz;
    always #20 mclk = ~mclk;
    ascbd_top dut (.mclk(mclk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sclk(sclk), .cs_n(cs_n),
        .din(din), .dout_o(dout_o), .dout_oe(dout_oe), .conversion_strobe_out(strb),
        .conversion_strobe_oe(strb_oe));
    ascbd_host host (.sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout_w));
    // ****************************************************************
    // Bus tasks and expectations
    // ****************************************************************
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge mclk);
        reg_wr    <= 1'b0;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input string n);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge mclk);
        reg_rd   <= 1'b0;
        #1 `CHK(n, e, reg_rdata)
    endtask
    function automatic logic [9:0] expv(input logic [7:0] b);
        logic [2:0]  p;
        logic [2:0]  m;
        logic [10:0] d;
        p = {b[5], b[4], b[6]};
        m = {b[5], b[4], ~b[6]};
        d = {1'b0, smp[p]} - {1'b0, smp[m]};
        if (b[2])
            return b[3] ? smp[p] : smp[p] ^ BIPOLAR_FLIP;
        return b[3] ? (d[10] ? 10'h000 : d[9:0]) : d[10:1];
    endfunction
    task automatic conv(input logic [7:0] b, input logic [15:0] n);
        logic [11:0] got;
        int          o;
        host.frame({6'h00, b, 26'h0}, cap);
        o = (b[1:0] == MODE_EXT_CLK) ? 16 : 17;
        for (int k = 0; k < 12; k++)
            got[11 - k] = cap[o + k];
        `CHK("result", {expv(b), 2'h0}, got)
        rd_chk(STATUS_ADDR, {n, 6'h00, b[1:0] == MODE_EXT_CLK, ~b[1], b}, "status");
        $display("test conv %h done", b);
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    initial
    begin
        #400000;
        error_cnt++;
        end_of_test();
    end
    initial
    begin
        repeat (12) @(posedge mclk);
        reset_n <= 1'b1;
        repeat (3) @(posedge mclk);
        host.frame(40'h0, cap);
        // No byte yet, so the reset mode field of zero reads back as full power-down.
        rd_chk(STATUS_ADDR, 32'h0000_0100, "zeros only");
        wr(STATUS_ADDR, 32'hFFFFFFFF);
        rd_chk(STATUS_ADDR, 32'h0000_0100, "status ro");
        rd_chk(8'h40, 32'h0, "unmapped");
        for (int i = 0; i < 8; i++)
        begin
            smp[i] = 10'(10'h05A * (i + 1));
            wr(SAMPLE_BASE + 8'(4 * i), {22'h3FFFFF, smp[i]});
            rd_chk(SAMPLE_BASE + 8'(4 * i), {22'h0, smp[i]}, "sample");
        end
        $display("test registers done");
        for (int i = 0; i < 6; i++)
            conv(tbl[i], 16'(i + 1));
        host.frame({40{1'b1}}, cap);
        rd_chk(STATUS_ADDR, {16'h0009, 8'h02, 8'hFF}, "held high");
        $display("test held high done");
        end_of_test();
    end
endmodule // tb_top
